// ===== ptk_params.svh
// Register offsets, field positions, reset values and widths of the tick counter
`ifndef PTK_PARAMS_SVH
`define PTK_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define PTK_ADDR_W 8
`define PTK_OFF_CTRL 8'h10
`define PTK_OFF_RELOAD 8'h14
`define PTK_OFF_CURRENT 8'h18
`define PTK_OFF_IRQ_STAT 8'h1C
`define PTK_OFF_IRQ_MASK 8'h20

// ==========================================================
// Field positions
`define PTK_CNT_W 24
`define PTK_BIT_ENABLE 0
`define PTK_BIT_REQ_EN 1
`define PTK_BIT_SRC_SEL 2
`define PTK_BIT_ZERO_FLAG 16
`define PTK_IRQ_N 1
`define PTK_IRQ_ZERO 0

// ==========================================================
// Reset values
`define PTK_RST_WORD 32'h0000_0000
`define PTK_RST_CNT 24'h00_0000
`define PTK_CNT_ONE 24'h00_0001

`endif

// ===== ptk_pkg.sv
// Types shared by the tick counter modules
`default_nettype none

package ptk_pkg;

	// ==========================================================
	// Counter run state
	typedef enum logic [1:0] {
		PTK_ST_OFF = 2'b01,
		PTK_ST_RUN = 2'b10
	} ptk_state_t;

	// ==========================================================
	// Register select
	typedef enum logic [5:0] {
		PTK_SEL_NONE = 6'h01,
		PTK_SEL_CTRL = 6'h02,
		PTK_SEL_RELOAD = 6'h04,
		PTK_SEL_CURRENT = 6'h08,
		PTK_SEL_STAT = 6'h10,
		PTK_SEL_MASK = 6'h20
	} ptk_sel_t;

endpackage

`default_nettype wire

// ===== ptk_sync.sv
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module ptk_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Level
	input wire logic d,
	output logic q
);

	logic meta_q;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule

`default_nettype wire

// ===== ptk_irq.sv
// Sticky interrupt status with write-one-to-clear, mask and level output
`timescale 1ns/1ps
`default_nettype none

module ptk_irq #(
	parameter int N = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Events
	input wire logic [N-1:0] evt,
	// Software access
	input wire logic wr_clr,
	input wire logic wr_mask,
	input wire logic [N-1:0] wdata,
	// State
	output logic [N-1:0] status,
	output logic [N-1:0] mask,
	output logic irq
);

	// ==========================================================
	// Status: a set in the clear cycle wins, so no event is lost
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					status[i] <= 1'b0;
				end else if (evt[i]) begin
					status[i] <= 1'b1;
				end else if (wr_clr && wdata[i]) begin
					status[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mask <= '0;
		end else if (wr_mask) begin
			mask <= wdata;
		end
	end

	assign irq = |(status & mask);

	a_evt_sticky: assert property (@(posedge clk) disable iff (!nrst)
		evt[0] |=> status[0])
		else $error("Event did not set its status bit");

endmodule

`default_nettype wire

// ===== ptk_top.sv
// Periodic 24-bit down counter with control, reload and current value registers
//
// Functional notes
// - Count from one to zero sets flag
// - Control read or current write clears flag
// - Source select 0 external reference, 1 core
// - Request enable pends exception at zero
// - Request disabled: no pend, poll flag
// - Software clear of count never pends
// - Enable 0 stops; 1 reloads repeatedly
// - 24-bit reload copied in at zero
// - Decrement, reload next tick, keep decrementing
// - Reload of zero holds count at zero
// - Any current value write clears count
`timescale 1ns/1ps
`default_nettype none
`include "ptk_params.svh"

module ptk_top #(
	parameter int CNT_W = `PTK_CNT_W
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Register port
	input wire logic [`PTK_ADDR_W-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// External reference clock, sampled
	input wire logic REF_CLK_IN,
	// Core side
	output logic TICK_PEND,
	output logic IRQ,
	output logic COUNTING
);

	// ==========================================================
	// Address decode
	function automatic ptk_pkg::ptk_sel_t sel_of(input logic [`PTK_ADDR_W-1:0] a);
		case (a)
			`PTK_OFF_CTRL: sel_of = ptk_pkg::PTK_SEL_CTRL;
			`PTK_OFF_RELOAD: sel_of = ptk_pkg::PTK_SEL_RELOAD;
			`PTK_OFF_CURRENT: sel_of = ptk_pkg::PTK_SEL_CURRENT;
			`PTK_OFF_IRQ_STAT: sel_of = ptk_pkg::PTK_SEL_STAT;
			`PTK_OFF_IRQ_MASK: sel_of = ptk_pkg::PTK_SEL_MASK;
			default: sel_of = ptk_pkg::PTK_SEL_NONE;
		endcase
	endfunction

	ptk_pkg::ptk_sel_t wr_sel;
	ptk_pkg::ptk_sel_t rd_sel;
	logic wr_ctrl;
	logic wr_reload;
	logic wr_current;
	logic rd_ctrl;

	assign wr_sel = WR ? sel_of(ADDR) : ptk_pkg::PTK_SEL_NONE;
	assign rd_sel = RD ? sel_of(ADDR) : ptk_pkg::PTK_SEL_NONE;
	assign wr_ctrl = (wr_sel == ptk_pkg::PTK_SEL_CTRL);
	assign wr_reload = (wr_sel == ptk_pkg::PTK_SEL_RELOAD);
	assign wr_current = (wr_sel == ptk_pkg::PTK_SEL_CURRENT);
	assign rd_ctrl = (rd_sel == ptk_pkg::PTK_SEL_CTRL);

	// ==========================================================
	// Control bits
	logic enable_q;
	logic req_en_q;
	logic src_sel_q;
	logic [CNT_W-1:0] reload_q;
	logic [CNT_W-1:0] cur_q;
	logic [CNT_W-1:0] cur_d;
	logic zero_flag_q;

	// Only defined bits are stored; the rest of a write is dropped
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			enable_q <= 1'b0;
			req_en_q <= 1'b0;
			src_sel_q <= 1'b0;
		end else if (wr_ctrl) begin
			enable_q <= WDATA[`PTK_BIT_ENABLE];
			req_en_q <= WDATA[`PTK_BIT_REQ_EN];
			src_sel_q <= WDATA[`PTK_BIT_SRC_SEL];
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			reload_q <= '0;
		end else if (wr_reload) begin
			reload_q <= WDATA[CNT_W-1:0];
		end
	end

	// ==========================================================
	// Reference clock: synchronise, then find its rising edge
	logic ref_sync;
	logic ref_prev_q;
	logic ref_rise;

	ptk_sync u_ref_sync (
		.clk(CLK),
		.nrst(NRST),
		.d(REF_CLK_IN),
		.q(ref_sync)
	);

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ref_prev_q <= 1'b0;
		end else begin
			ref_prev_q <= ref_sync;
		end
	end

	// Reference must run below half the core rate to be seen
	assign ref_rise = ref_sync && !ref_prev_q;

	// ==========================================================
	// Run state
	ptk_pkg::ptk_state_t state_q;
	ptk_pkg::ptk_state_t state_d;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ptk_pkg::PTK_ST_OFF: begin
				if (enable_q) begin
					state_d = ptk_pkg::PTK_ST_RUN;
				end
			end
			ptk_pkg::PTK_ST_RUN: begin
				if (!enable_q) begin
					state_d = ptk_pkg::PTK_ST_OFF;
				end
			end
			default: begin
				state_d = ptk_pkg::PTK_ST_OFF;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_q <= ptk_pkg::PTK_ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// Counter
	logic tick;
	logic zero_evt;

	// Counting stops at once when enable drops
	assign tick = enable_q && (src_sel_q ? 1'b1 : ref_rise);
	assign zero_evt = tick && !wr_current && (cur_q == `PTK_CNT_ONE);

	always_comb begin
		cur_d = cur_q;
		if (wr_current) begin
			cur_d = '0;
		end else if (tick) begin
			if (cur_q == '0) begin
				cur_d = reload_q;
			end else begin
				cur_d = cur_q - 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			cur_q <= '0;
		end else begin
			cur_q <= cur_d;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			zero_flag_q <= 1'b0;
		end else if (zero_evt) begin
			zero_flag_q <= 1'b1;
		end else if (rd_ctrl || wr_current) begin
			zero_flag_q <= 1'b0;
		end
	end

	// ==========================================================
	// Exception pend and interrupt
	logic pend_set;
	logic [`PTK_IRQ_N-1:0] irq_stat;
	logic [`PTK_IRQ_N-1:0] irq_mask;

	// Software clearing never reaches zero_evt, so never pends
	assign pend_set = zero_evt && req_en_q;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			TICK_PEND <= 1'b0;
		end else begin
			TICK_PEND <= pend_set;
		end
	end

	ptk_irq #(
		.N(`PTK_IRQ_N)
	) u_irq (
		.clk(CLK),
		.nrst(NRST),
		.evt(pend_set),
		.wr_clr(wr_sel == ptk_pkg::PTK_SEL_STAT),
		.wr_mask(wr_sel == ptk_pkg::PTK_SEL_MASK),
		.wdata(WDATA[`PTK_IRQ_N-1:0]),
		.status(irq_stat),
		.mask(irq_mask),
		.irq(IRQ)
	);

	assign COUNTING = (state_q == ptk_pkg::PTK_ST_RUN);

	// ==========================================================
	// Read data, one cycle after the strobe
	logic [31:0] rd_word;

	always_comb begin
		rd_word = `PTK_RST_WORD;
		case (rd_sel)
			ptk_pkg::PTK_SEL_CTRL: begin
				rd_word[`PTK_BIT_ENABLE] = enable_q;
				rd_word[`PTK_BIT_REQ_EN] = req_en_q;
				rd_word[`PTK_BIT_SRC_SEL] = src_sel_q;
				rd_word[`PTK_BIT_ZERO_FLAG] = zero_flag_q;
			end
			ptk_pkg::PTK_SEL_RELOAD: rd_word[CNT_W-1:0] = reload_q;
			ptk_pkg::PTK_SEL_CURRENT: rd_word[CNT_W-1:0] = cur_q;
			ptk_pkg::PTK_SEL_STAT: rd_word[`PTK_IRQ_N-1:0] = irq_stat;
			ptk_pkg::PTK_SEL_MASK: rd_word[`PTK_IRQ_N-1:0] = irq_mask;
			default: rd_word = `PTK_RST_WORD;
		endcase
	end

	// Data valid only in the cycle after a read; zero otherwise
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			RDATA <= `PTK_RST_WORD;
		end else begin
			RDATA <= rd_word;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);

	sequence s_last_step;
		tick && !wr_current && (cur_q == `PTK_CNT_ONE);
	endsequence

	sequence s_wrap;
		tick && !wr_current && (cur_q == '0);
	endsequence

	a_flag_on_zero: assert property (s_last_step |=> zero_flag_q && (cur_q == '0))
		else $error("Flag not set on count to zero");

	a_flag_read_clr: assert property ((rd_ctrl || wr_current) && !zero_evt |=> !zero_flag_q)
		else $error("Flag not cleared by read or write");

	a_src_core: assert property (enable_q && src_sel_q |-> tick)
		else $error("Core clock source did not tick");

	a_src_ref: assert property (!src_sel_q && tick |-> $past(ref_sync, 1) == 1'b0 && ref_sync)
		else $error("Reference tick without rising edge");

	a_pend_zero: assert property (s_last_step ##0 req_en_q |=> TICK_PEND ##1 !TICK_PEND)
		else $error("Exception not pended at zero");

	a_no_pend_off: assert property (!req_en_q |=> !TICK_PEND)
		else $error("Pended while request disabled");

	a_pend_cause: assert property (TICK_PEND |-> $past(tick) && !$past(wr_current)
		&& $past(cur_q) == `PTK_CNT_ONE)
		else $error("Pend without a counted step to zero");

	a_stop_hold: assert property (!enable_q && !wr_current |=> $stable(cur_q))
		else $error("Counter moved while disabled");

	a_wrap_load: assert property (s_wrap |=> cur_q == $past(reload_q))
		else $error("Reload not copied at zero");

	a_step_down: assert property (tick && !wr_current && cur_q != '0 |=> cur_q == $past(cur_q) - 1'b1)
		else $error("Counter did not decrement");

	// Flag may still stand from the step before, so only count and pend are held
	a_zero_idle: assert property (s_wrap ##0 (reload_q == '0) |=> cur_q == '0 && !TICK_PEND)
		else $error("Zero reload did not hold count");

	a_write_clear: assert property (wr_current |=> cur_q == '0 && !TICK_PEND)
		else $error("Current value write did not clear");

	a_reserved_zero: assert property (RD |=> RDATA[31:CNT_W] == '0)
		else $error("Reserved bits read non-zero");

	a_ctrl_reserved: assert property (rd_ctrl |=>
		RDATA[31:`PTK_BIT_ZERO_FLAG+1] == '0
		&& RDATA[`PTK_BIT_ZERO_FLAG-1:`PTK_BIT_SRC_SEL+1] == '0)
		else $error("Reserved control bits read non-zero");

endmodule

`default_nettype wire

// ===== ptk_core_model.sv
// Core-side model that counts pended tick exceptions
`timescale 1ns/1ps
`default_nettype none

module ptk_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Exception pend from the counter
	input wire logic pend,
	output var int taken
);
	// One pulse is one exception; a stuck level overcounts at once
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			taken <= 0;
		end else if (pend === 1'b1) begin
			taken <= taken + 1;
		end
	end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the tick counter
`timescale 1ns/1ps
`default_nettype none
`include "ptk_params.svh"

module tb_top;
	// ==========================================================
	// Signals
	logic clk, nrst, wr, rd, ref_in, tick_pend, irq, counting;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, rnd;
	int taken, seed, n_mismatch, comparisons, m_pends, tick;
	int m_cur, m_rel, m_ctl, m_flag, m_stat, m_mask, m_pend, m_rd, r1, r2, r3;
	int m_run, m_old_rel, m_old_req;

	ptk_top i_dut (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .REF_CLK_IN(ref_in), .TICK_PEND(tick_pend), .IRQ(irq),
		.COUNTING(counting));
	ptk_core_model i_core (.clk(clk), .nrst(nrst), .pend(tick_pend), .taken(taken));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// Reference model
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{m_cur, m_rel, m_ctl, m_flag, m_stat, m_mask, m_pend, m_rd, r1, r2, r3, m_run} = '0;
		end else begin
			// Old control decides this edge; a control write lands next cycle
			tick = m_ctl[0] && (m_ctl[2] || (r2 && !r3));
			// Run state follows enable one cycle later
			m_run = m_ctl[0];
			// Reload and request enable written this edge act only from the next
			m_old_req = m_ctl[1];
			m_old_rel = m_rel;
			r3 = r2;
			r2 = r1;
			r1 = ref_in;
			m_rd = 0;
			m_pend = 0;
			if (rd) begin
				case (addr)
					`PTK_OFF_CTRL: m_rd = m_ctl | (m_flag << 16);
					`PTK_OFF_RELOAD: m_rd = m_rel;
					`PTK_OFF_CURRENT: m_rd = m_cur;
					`PTK_OFF_IRQ_STAT: m_rd = m_stat;
					`PTK_OFF_IRQ_MASK: m_rd = m_mask;
					default: m_rd = 0;
				endcase
				if (addr == `PTK_OFF_CTRL) m_flag = 0;
			end
			if (wr) begin
				case (addr)
					`PTK_OFF_CTRL: m_ctl = wdata & 32'h0000_0007;
					`PTK_OFF_RELOAD: m_rel = wdata & 32'h00FF_FFFF;
					`PTK_OFF_CURRENT: begin
						m_cur = 0;
						m_flag = 0;
					end
					`PTK_OFF_IRQ_STAT: if (wdata[0]) m_stat = 0;
					`PTK_OFF_IRQ_MASK: m_mask = wdata & 32'h0000_0001;
					default: ;
				endcase
			end
			// Set after clears, so an event in a clearing cycle survives
			if (tick && !(wr && addr == `PTK_OFF_CURRENT)) begin
				if (m_cur == 0) begin
					m_cur = m_old_rel;
				end else begin
					if (m_cur == 1) begin
						m_flag = 1;
						m_pend = m_old_req;
						m_stat = m_stat | m_old_req;
					end
					m_cur = m_cur - 1;
				end
			end
			m_pends = m_pends + m_pend;
		end
	end

	// ==========================================================
	// Checks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	always @(negedge clk) begin
		if (nrst) begin
			chk(rdata, m_rd);
			chk({31'h0, tick_pend}, m_pend);
			chk({31'h0, irq}, m_stat & m_mask);
			chk({31'h0, counting}, m_run);
		end
	end

	task automatic results();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Bus tasks
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
	endtask

	task automatic poll(input int n);
		for (int i = 0; i < n; i++) begin
			rd_reg(`PTK_OFF_CTRL);
			rd_reg(`PTK_OFF_CURRENT);
		end
	endtask

	// ==========================================================
	// Stimulus
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		results();
	end

	initial begin
		seed = 32'h6050EF8A;
		{wr, rd, addr, wdata, ref_in, nrst} = '0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		for (int a = 16; a <= 36; a += 4) rd_reg(a[7:0]);
		wr_reg(8'h24, 32'hFFFF_FFFF);
		for (int i = 0; i < 4; i++) begin
			rnd = $random(seed);
			wr_reg(`PTK_OFF_RELOAD, rnd);
			rd_reg(`PTK_OFF_RELOAD);
			wr_reg(`PTK_OFF_CURRENT, rnd);
			rd_reg(`PTK_OFF_CURRENT);
		end
		// Periodic run, reserved control bits written high
		wr_reg(`PTK_OFF_IRQ_MASK, 32'hFFFF_FFFF);
		wr_reg(`PTK_OFF_RELOAD, 32'h0000_0003);
		wr_reg(`PTK_OFF_CTRL, 32'hFFFE_FFFF);
		poll(10);
		wr_reg(`PTK_OFF_IRQ_MASK, 32'h0000_0000);
		wr_reg(`PTK_OFF_IRQ_MASK, 32'h0000_0001);
		wr_reg(`PTK_OFF_IRQ_STAT, 32'h0000_0001);
		for (int i = 0; i < 12; i++) begin
			rnd = $random(seed);
			wr_reg(`PTK_OFF_CURRENT, rnd);
			repeat (rnd[1:0]) @(posedge clk);
		end
		// Polling only, no pend
		wr_reg(`PTK_OFF_CTRL, 32'h0000_0005);
		poll(8);
		wr_reg(`PTK_OFF_RELOAD, 32'h0000_0000);
		poll(5);
		wr_reg(`PTK_OFF_RELOAD, 32'h0000_0005);
		wr_reg(`PTK_OFF_CTRL, 32'h0000_0000);
		poll(4);
		// External reference, well below half the core rate
		wr_reg(`PTK_OFF_RELOAD, 32'h0000_0004);
		wr_reg(`PTK_OFF_CTRL, 32'h0000_0001);
		for (int i = 0; i < 12; i++) begin
			ref_in <= 1'b1;
			repeat (4) @(posedge clk);
			ref_in <= 1'b0;
			repeat (4) @(posedge clk);
			if (i % 3 == 2) poll(1);
		end
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk(taken, m_pends);
		results();
	end
endmodule
`default_nettype wire
